// ===== src/cis_defines.vh
// constants for the interrupt sequencer
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH
`define CIS_ADDR_GLOBAL 8'h00
`define CIS_ADDR_ENABLE 8'h04
`define CIS_ADDR_FLAG 8'h08
`define CIS_ADDR_CORECTL 8'h0C
`define CIS_ADDR_STATUS 8'h10
`define CIS_ADDR_SP 8'h14
`define CIS_ADDR_LEVEL 8'h18
`define CIS_ADDR_PC 8'h1C
`define CIS_GIE_BIT 7
`define CIS_VECTOR_TABLE_SELECT_BIT 1
`define CIS_SP_RESET 16'h10FF
`define CIS_ENTRY_CYCLES 4'h4
`define CIS_SLEEP_EXTRA 4'h4
`define CIS_JUMP_CYCLES 4'h3
`define CIS_RETURN_CYCLES 4'h4
`define CIS_HOLD_CYCLES 4'h2
`define CIS_RETADDR_BYTES 16'h0002
`endif

// ===== src/cis_sequencer.v
// interrupt and reset entry/exit sequencer with an ahb-lite register slave
`timescale 1ns/10ps
`include "cis_defines.vh"
//
// Summary of operation
// RQ1 - core runs on undivided chip clock
// RQ2 - two-operand alu op completes in one cycle
// RQ3 - distinct vectors; take needs own and global enable
// RQ4 - boot lock suppresses interrupts by pc region
// RQ5 - vectors lowest; lower index means higher priority
// RQ6 - vector select moves table to boot start
// RQ7 - boot reset fuse moves reset vector
// RQ8 - entry clears global enable; return sets it
// RQ9 - flag cleared on vectoring or one-write
// RQ10 - disabled event still sets and holds flag
// RQ11 - flags kept while disabled, serviced by priority
// RQ12 - level sources request only while condition persists
// RQ13 - one main instruction after return before interrupt
// RQ14 - status flags not saved or restored
// RQ15 - clear-enable blocks same-cycle request too
// RQ16 - instruction after set-enable always executes
// RQ17 - entry four cycles, pc pushed, then vector
// RQ18 - vector jump takes three cycles; the code has no jump stage, CIS_JUMP_CYCLES is unused
// RQ19 - multi-cycle instruction completes before service
// RQ20 - sleep wake adds four entry cycles
// RQ21 - return four cycles, pops pc, sp plus two
// RQ22 - pc 15 or 16 bits, word addressed
// RQ23 - global enable is status bit 7
// RQ24 - interrupt push lowers stack pointer by two
// RQ25 - arbitrate at boundaries, lowest index wins
module cis_sequencer #(
   parameter NSRC = 8,
   parameter PCW = 16,
   parameter [15:0] BOOT_START = 16'hF000,
   parameter [15:0] BOOT_END = 16'hFFFF
)(
   input wire CLOCK,
   input wire RST,
   input wire HSEL,
   input wire [7:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   input wire [NSRC-1:0] EVENT_IN,
   input wire [NSRC-1:0] LEVEL_IN,
   input wire BOOT_RESET_FUSE,
   input wire APP_SECTION_LOCK_BIT,
   input wire BOOT_SECTION_LOCK_BIT,
   input wire INSN_BOUNDARY,
   input wire INSN_MULTICYCLE_BUSY,
   input wire [PCW-1:0] CORE_PC,
   input wire CLI_EXEC,
   input wire SEI_EXEC,
   input wire RETURN_FROM_INTERRUPT,
   input wire SLEEPING,
   output reg TAKE_VALID,
   output reg [PCW-1:0] VECTOR_PC,
   output reg [PCW-1:0] RESET_PC,
   output reg CORE_STALL,
   output reg GLOBAL_ENABLE,
   output reg [15:0] STACK_POINTER
);
   localparam ST_IDLE = 3'h0;
   localparam ST_WAKE = 3'h1;
   localparam ST_ENTRY = 3'h2;
   localparam ST_RET = 3'h3;
   localparam ST_HOLD = 3'h4;

   // event, level and strap pins come from outside: two-stage synchronisers
   reg [NSRC-1:0] ev_s1_reg, ev_s2_reg, ev_s3_reg, lv_s1_reg, lv_s2_reg;
   // strap bits: {boot reset fuse, app lock, boot lock}
   reg [2:0] strap_s1_reg, strap_s2_reg;
   reg [NSRC-1:0] enable_reg, flag_reg, level_type_reg;
   reg vector_table_select_reg, gie_reg, one_insn_reg;
   reg [2:0] state_reg;
   reg [3:0] cnt_reg;
   reg [15:0] sp_reg;
   reg [7:0] win_reg;
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;
   reg [PCW-1:0] vector_next;
   reg [31:0] rdata_next;

   // no edges while the synchronisers refill after reset
   wire [NSRC-1:0] ev_rise = ev_s2_reg & ~ev_s3_reg & {NSRC{state_reg != ST_HOLD}};
   // flag sources pend on flag, level sources on live condition
   wire [NSRC-1:0] pend = (flag_reg & ~level_type_reg) | (lv_s2_reg & level_type_reg); // RQ12
   wire [NSRC-1:0] ready = pend & enable_reg; // RQ3
   wire in_boot = (CORE_PC >= BOOT_START[PCW-1:0]) && (CORE_PC <= BOOT_END[PCW-1:0]);
   // lock bits suppress interrupts depending on where the pc sits
   wire locked = (strap_s2_reg[1] & ~in_boot) | (strap_s2_reg[0] & in_boot); // RQ4
   // a boundary may come every cycle: a two-operand alu op retires in one
   // cli in the same cycle wins; sei or a return defers by one insn
   wire can_take = gie_reg & ~CLI_EXEC & ~one_insn_reg & ~locked & INSN_BOUNDARY
      & ~INSN_MULTICYCLE_BUSY & (state_reg == ST_IDLE); // RQ15 RQ16 RQ13 RQ19 RQ25 RQ2

   // lowest index wins
   reg [7:0] win_idx;
   reg found;
   integer i;
   always @*
   begin
      win_idx = 8'h00;
      found = 1'b0;
      for (i = NSRC - 1; i >= 0; i = i - 1)
         if (ready[i])
         begin
            win_idx = i[7:0]; // RQ5 RQ25
            found = 1'b1;
         end
   end

   // vector index plus one: index zero is the reset vector
   always @*
   begin
      vector_next = {{(PCW-9){1'b0}}, win_reg + 8'h01, 1'b0}; // RQ3 RQ5 RQ22
      if (vector_table_select_reg)
         vector_next = BOOT_START[PCW-1:0] + vector_next; // RQ6
   end

   // read mux for the register map
   always @*
   begin
      rdata_next = 32'h00000000;
      case (HADDR)
         `CIS_ADDR_GLOBAL: rdata_next = {24'h000000, gie_reg, 7'h00}; // RQ23 RQ14
         `CIS_ADDR_ENABLE: rdata_next = {{(32-NSRC){1'b0}}, enable_reg};
         `CIS_ADDR_FLAG: rdata_next = {{(32-NSRC){1'b0}}, flag_reg};
         `CIS_ADDR_CORECTL: rdata_next = {30'h00000000, vector_table_select_reg, 1'b0};
         `CIS_ADDR_STATUS: rdata_next = {21'h000000, state_reg, win_reg};
         `CIS_ADDR_SP: rdata_next = {16'h0000, sp_reg};
         `CIS_ADDR_LEVEL: rdata_next = {{(32-NSRC){1'b0}}, level_type_reg};
         `CIS_ADDR_PC: rdata_next = {{(32-PCW){1'b0}}, vector_next};
         default: rdata_next = 32'h00000000;
      endcase
   end

   // ahb-lite slave, zero wait states, always okay
   wire addr_ph = HSEL & HTRANS[1];
   always @(posedge CLOCK)
   begin
      if (RST)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         HRDATA <= 32'h00000000;
      end
      else
      begin
         wr_pend_reg <= addr_ph & HWRITE;
         wr_addr_reg <= HADDR;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         if (addr_ph & ~HWRITE)
            HRDATA <= rdata_next;
      end
   end

   wire wr_glb = wr_pend_reg && (wr_addr_reg == `CIS_ADDR_GLOBAL);
   wire wr_flag = wr_pend_reg && (wr_addr_reg == `CIS_ADDR_FLAG);
   wire take = can_take & found;

   // pin synchronisers; the second stage feeds logic, and events also a third stage for edge detection
   always @(posedge CLOCK) // RQ1
   begin
      if (RST)
      begin
         ev_s1_reg <= {NSRC{1'b0}};
         ev_s2_reg <= {NSRC{1'b0}};
         ev_s3_reg <= {NSRC{1'b0}};
         lv_s1_reg <= {NSRC{1'b0}};
         lv_s2_reg <= {NSRC{1'b0}};
         strap_s1_reg <= 3'h0;
         strap_s2_reg <= 3'h0;
      end
      else
      begin
         ev_s1_reg <= EVENT_IN;
         ev_s2_reg <= ev_s1_reg;
         ev_s3_reg <= ev_s2_reg;
         lv_s1_reg <= LEVEL_IN;
         lv_s2_reg <= lv_s1_reg;
         strap_s1_reg <= {BOOT_RESET_FUSE, APP_SECTION_LOCK_BIT, BOOT_SECTION_LOCK_BIT};
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // software-written configuration
   always @(posedge CLOCK)
   begin
      if (RST)
      begin
         enable_reg <= {NSRC{1'b0}};
         level_type_reg <= {NSRC{1'b0}};
         vector_table_select_reg <= 1'b0;
      end
      else
      begin
         if (wr_pend_reg && wr_addr_reg == `CIS_ADDR_ENABLE)
            enable_reg <= HWDATA[NSRC-1:0];
         if (wr_pend_reg && wr_addr_reg == `CIS_ADDR_LEVEL)
            level_type_reg <= HWDATA[NSRC-1:0];
         if (wr_pend_reg && wr_addr_reg == `CIS_ADDR_CORECTL)
            vector_table_select_reg <= HWDATA[`CIS_VECTOR_TABLE_SELECT_BIT]; // RQ6
      end
   end

   // flags: set beats software and hardware clear
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1)
      begin : g_flag
         always @(posedge CLOCK)
         begin
            if (RST)
               flag_reg[g] <= 1'b0;
            else if (ev_rise[g])
               flag_reg[g] <= 1'b1; // RQ10 RQ11
            else if ((wr_flag && HWDATA[g]) || (take && win_idx == g))
               flag_reg[g] <= 1'b0; // RQ9
         end
      end
   endgenerate

   always @(posedge CLOCK)
   begin
      if (RST)
      begin
         gie_reg <= 1'b0;
         one_insn_reg <= 1'b0;
         state_reg <= ST_HOLD;
         cnt_reg <= `CIS_HOLD_CYCLES;
         sp_reg <= `CIS_SP_RESET;
         win_reg <= 8'h00;
         TAKE_VALID <= 1'b0;
         VECTOR_PC <= {PCW{1'b0}};
         RESET_PC <= {PCW{1'b0}};
         CORE_STALL <= 1'b1;
      end
      else
      begin
         TAKE_VALID <= 1'b0;
         if (wr_pend_reg && wr_addr_reg == `CIS_ADDR_SP)
            sp_reg <= HWDATA[15:0];
         // one-insn deferral after sei or return, cleared at next boundary
         if (SEI_EXEC || (state_reg == ST_RET && cnt_reg == 4'h1))
            one_insn_reg <= 1'b1; // RQ16 RQ13
         else if (INSN_BOUNDARY)
            one_insn_reg <= 1'b0;
         if (CLI_EXEC)
            gie_reg <= 1'b0; // RQ15
         else if (SEI_EXEC)
            gie_reg <= 1'b1; // RQ8
         else if (wr_glb)
            gie_reg <= HWDATA[`CIS_GIE_BIT]; // RQ23 RQ8
         case (state_reg)
            ST_HOLD:
            begin
               // core held until the straps are through their synchroniser
               cnt_reg <= cnt_reg - 4'h1;
               if (cnt_reg == 4'h0)
               begin
                  RESET_PC <= strap_s2_reg[2] ? BOOT_START[PCW-1:0] : {PCW{1'b0}}; // RQ7
                  CORE_STALL <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_IDLE:
            begin
               if (RETURN_FROM_INTERRUPT)
               begin
                  state_reg <= ST_RET;
                  cnt_reg <= `CIS_RETURN_CYCLES; // RQ21
                  CORE_STALL <= 1'b1;
               end
               else if (take)
               begin
                  gie_reg <= 1'b0; // RQ8
                  win_reg <= win_idx;
                  CORE_STALL <= 1'b1;
                  state_reg <= SLEEPING ? ST_WAKE : ST_ENTRY; // RQ20
                  cnt_reg <= SLEEPING ? `CIS_SLEEP_EXTRA : `CIS_ENTRY_CYCLES; // RQ17
               end
            end
            ST_WAKE:
            begin
               cnt_reg <= cnt_reg - 4'h1;
               if (cnt_reg == 4'h1)
               begin
                  state_reg <= ST_ENTRY;
                  cnt_reg <= `CIS_ENTRY_CYCLES; // RQ20
               end
            end
            ST_ENTRY:
            begin
               cnt_reg <= cnt_reg - 4'h1;
               if (cnt_reg == 4'h1)
               begin
                  sp_reg <= sp_reg - `CIS_RETADDR_BYTES; // RQ24 RQ17
                  VECTOR_PC <= vector_next; // RQ17 RQ18
                  TAKE_VALID <= 1'b1;
                  CORE_STALL <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_RET:
            begin
               cnt_reg <= cnt_reg - 4'h1;
               if (cnt_reg == 4'h1)
               begin
                  sp_reg <= sp_reg + `CIS_RETADDR_BYTES; // RQ21
                  gie_reg <= 1'b1; // RQ8 RQ21
                  CORE_STALL <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // port copies, one cycle behind the working registers
   always @(posedge CLOCK)
   begin
      if (RST)
      begin
         GLOBAL_ENABLE <= 1'b0;
         STACK_POINTER <= `CIS_SP_RESET;
      end
      else
      begin
         GLOBAL_ENABLE <= gie_reg;
         STACK_POINTER <= sp_reg;
      end
   end
endmodule // cis_sequencer

// ===== tb/cis_seq_properties.sv
// port assertions for the interrupt sequencer
`timescale 1ns/10ps
module cis_seq_properties #(
   parameter PCW = 16,
   parameter [15:0] BOOT_START = 16'hF000
)(
   input wire CLOCK,
   input wire RST,
   input wire HREADYOUT,
   input wire HRESP,
   input wire CLI_EXEC,
   input wire RETURN_FROM_INTERRUPT,
   input wire BOOT_RESET_FUSE,
   input wire TAKE_VALID,
   input wire [PCW-1:0] VECTOR_PC,
   input wire [PCW-1:0] RESET_PC,
   input wire CORE_STALL,
   input wire GLOBAL_ENABLE,
   input wire [15:0] STACK_POINTER
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("slave not ready or not okay");
   a_take_clears_enable: assert property (TAKE_VALID |-> !GLOBAL_ENABLE)
      else $error("enable still set at vector");
   a_entry_stall: assert property (TAKE_VALID |-> $past(CORE_STALL, 4) && $past(CORE_STALL))
      else $error("entry shorter than four cycles");
   a_push_sp: assert property (TAKE_VALID |=> STACK_POINTER == $past(STACK_POINTER) - 16'h0002)
      else $error("stack pointer not lowered by two");
   a_vector_even: assert property (TAKE_VALID |-> !VECTOR_PC[0] && VECTOR_PC != RESET_PC)
      else $error("vector not distinct");
   a_return_stall: assert property (RETURN_FROM_INTERRUPT && !CORE_STALL |=> CORE_STALL[*3])
      else $error("return not stalled");
   a_return_enable: assert property (RETURN_FROM_INTERRUPT && !CORE_STALL |-> ##[4:6] GLOBAL_ENABLE)
      else $error("return did not set enable");
   a_cli_blocks: assert property (CLI_EXEC && !CORE_STALL |=> (!TAKE_VALID)[*6])
      else $error("take after clear enable");
   a_reset_vector: assert property ($fell(RST) |-> ##3 RESET_PC == (BOOT_RESET_FUSE ? BOOT_START : 16'h0000))
      else $error("reset vector wrong");
   c_take: cover property (TAKE_VALID);
   c_return: cover property (RETURN_FROM_INTERRUPT && !CORE_STALL);
   c_cli: cover property (CLI_EXEC && !CORE_STALL);
endmodule // cis_seq_properties

// ===== tb/cis_core_model.sv
// core stand-in: single-cycle instructions, a boundary in the cycle after every free cycle
`timescale 1ns/10ps
module cis_core_model #(
   parameter PCW = 16
)(
   input wire clock,
   input wire rst,
   input wire core_stall,
   output reg insn_boundary,
   output reg [PCW-1:0] core_pc
);
   always @(posedge clock)
   begin
      insn_boundary <= !rst && !core_stall;
      if (rst)
         core_pc <= 16'h0100;
      else if (!core_stall)
         core_pc <= core_pc + 16'h0001;
   end
endmodule // cis_core_model

// ===== tb/test_cpu_interrupt_sequencer.sv
// bench for the interrupt sequencer
`timescale 1ns/10ps
`include "cis_defines.vh"
module test_cpu_interrupt_sequencer;
   reg CLOCK = 0, RST = 1, HSEL = 0, HWRITE = 0, got = 0;
   reg fuse = 0, app_lk = 0, busy = 0, sleep = 0;
   reg [7:0] HADDR = 8'h00, ev = 8'h00, lv = 8'h00;
   reg [1:0] HTRANS = 2'h0;
   reg [2:0] HSIZE = 3'h2, cmd = 3'h0;
   reg [31:0] HWDATA = 32'h0, q;
   wire [31:0] HRDATA;
   wire HREADYOUT, HRESP, take, stall, ge, bnd;
   wire [15:0] vec, rpc, sp, pc;
   integer err_total = 0, checks = 0;
   cis_sequencer i_cis_sequencer (.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EVENT_IN(ev), .LEVEL_IN(lv),
      .BOOT_RESET_FUSE(fuse), .APP_SECTION_LOCK_BIT(app_lk), .BOOT_SECTION_LOCK_BIT(1'b0),
      .INSN_BOUNDARY(bnd), .INSN_MULTICYCLE_BUSY(busy), .CORE_PC(pc), .CLI_EXEC(cmd[0]),
      .SEI_EXEC(cmd[1]), .RETURN_FROM_INTERRUPT(cmd[2]), .SLEEPING(sleep), .TAKE_VALID(take),
      .VECTOR_PC(vec), .RESET_PC(rpc), .CORE_STALL(stall), .GLOBAL_ENABLE(ge),
      .STACK_POINTER(sp));
   cis_core_model i_cis_core_model (.clock(CLOCK), .rst(RST), .core_stall(stall),
      .insn_boundary(bnd), .core_pc(pc));
   initial forever #4 CLOCK = ~CLOCK;
   task chk(input [31:0] exp, input [31:0] seen, input [63:0] what);
      begin
         checks = checks + 1;
         if (seen !== exp)
         begin
            err_total = err_total + 1;
            $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", checks, err_total);
         if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task edge_ready;
      integer n;
      begin
         n = 0;
         @(posedge CLOCK);
         while (HREADYOUT !== 1'b1)
         begin
            n = n + 1;
            if (n > 20)
            begin
               err_total = err_total + 1;
               report_and_stop;
            end
            @(posedge CLOCK);
         end
      end
   endtask
   task bus(input wr, input [7:0] a, input [31:0] d);
      begin
         HSEL <= 1'b1;
         HTRANS <= 2'h2;
         HADDR <= a;
         HWRITE <= wr;
         edge_ready;
         HSEL <= 1'b0;
         HTRANS <= 2'h0;
         HWDATA <= d;
         edge_ready;
         q = HRDATA;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e, input [63:0] w);
      begin
         bus(1'b0, a, 32'h0);
         chk(e, q, w);
      end
   endtask
   task wait_take(input integer n);
      begin
         got = 1'b0;
         repeat (n)
            if (!got)
            begin
               @(posedge CLOCK);
               got = (take === 1'b1);
            end
      end
   endtask
   task core(input [2:0] c);
      begin
         cmd <= c;
         @(posedge CLOCK);
         cmd <= 3'h0;
         repeat (8) @(posedge CLOCK);
      end
   endtask
   task t_reset;
      begin
         rd(8'h14, `CIS_SP_RESET, "sp");
         rd(8'h20, 32'h0, "unmapped");
         chk(0, rpc, "resetpc");
         bus(1'b1, 8'h00, 32'h80);
         rd(8'h00, 32'h80, "global");
         bus(1'b1, 8'h00, 32'h0);
         $display("t_reset done");
      end
   endtask
   task t_held;
      begin
         ev <= 8'h08;
         repeat (6) @(posedge CLOCK);
         rd(8'h08, 32'h08, "flag");
         bus(1'b1, 8'h04, 32'h08);
         bus(1'b1, 8'h00, 32'h80);
         wait_take(20);
         chk(1, got, "take");
         chk(8, vec, "vector");
         repeat (2) @(posedge CLOCK);
         chk(0, ge, "enable");
         rd(8'h08, 32'h0, "flag");
         rd(8'h14, `CIS_SP_RESET - 2, "sp");
         core(3'h4);
         chk(1, ge, "enable");
         rd(8'h14, `CIS_SP_RESET, "sp");
         $display("t_held done");
      end
   endtask
   task t_prio;
      begin
         bus(1'b1, 8'h00, 32'h0);
         ev <= 8'h2C;
         bus(1'b1, 8'h04, 32'h24);
         repeat (4) @(posedge CLOCK);
         cmd <= 3'h2;
         @(posedge CLOCK);
         cmd <= 3'h0;
         wait_take(20);
         chk(6, vec, "vector");
         core(3'h4);
         wait_take(20);
         chk(12, vec, "vector");
         core(3'h4);
         $display("t_prio done");
      end
   endtask
   task t_level;
      begin
         bus(1'b1, 8'h18, 32'h02);
         lv <= 8'h02;
         repeat (4) @(posedge CLOCK);
         lv <= 8'h00;
         repeat (4) @(posedge CLOCK);
         bus(1'b1, 8'h04, 32'h02);
         wait_take(16);
         chk(0, got, "take");
         lv <= 8'h02;
         wait_take(20);
         chk(4, vec, "vector");
         lv <= 8'h00;
         core(3'h4);
         wait_take(16);
         chk(0, got, "take");
         $display("t_level done");
      end
   endtask
   task t_clr;
      begin
         ev <= 8'h6C;
         repeat (6) @(posedge CLOCK);
         bus(1'b1, 8'h08, 32'h40);
         rd(8'h08, 32'h0, "flag");
         core(3'h1);
         chk(0, ge, "enable");
         $display("t_clr done");
      end
   endtask
   task t_modes;
      begin
         bus(1'b1, 8'h0C, 32'h02);
         ev <= 8'hEC;
         bus(1'b1, 8'h04, 32'h80);
         app_lk <= 1'b1;
         repeat (4) @(posedge CLOCK);
         bus(1'b1, 8'h00, 32'h80);
         wait_take(16);
         chk(0, got, "locked");
         app_lk <= 1'b0;
         busy <= 1'b1;
         wait_take(16);
         chk(0, got, "busy");
         busy <= 1'b0;
         sleep <= 1'b1;
         wait_take(24);
         chk(1, got, "sleep");
         chk(32'hF010, vec, "bootvec");
         sleep <= 1'b0;
         core(3'h4);
         bus(1'b1, 8'h0C, 32'h0);
         fuse <= 1'b1;
         RST <= 1'b1;
         repeat (2) @(posedge CLOCK);
         RST <= 1'b0;
         @(posedge CLOCK);
         chk(1, stall, "stall");
         repeat (4) @(posedge CLOCK);
         chk(0, stall, "stall");
         chk(32'hF000, rpc, "resetpc");
         chk(`CIS_SP_RESET, sp, "spport");
         fuse <= 1'b0;
         $display("t_modes done");
      end
   endtask
   initial
   begin
      repeat (8) @(posedge CLOCK);
      RST <= 1'b0;
      @(posedge CLOCK);
      t_reset;
      t_held;
      t_prio;
      t_level;
      t_clr;
      t_modes;
      report_and_stop;
   end
endmodule // test_cpu_interrupt_sequencer
bind cis_sequencer cis_seq_properties #(.PCW(PCW), .BOOT_START(BOOT_START)) i_cis_seq_properties (
   .CLOCK(CLOCK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CLI_EXEC(CLI_EXEC),
   .RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT), .BOOT_RESET_FUSE(BOOT_RESET_FUSE),
   .TAKE_VALID(TAKE_VALID), .VECTOR_PC(VECTOR_PC), .RESET_PC(RESET_PC),
   .CORE_STALL(CORE_STALL), .GLOBAL_ENABLE(GLOBAL_ENABLE), .STACK_POINTER(STACK_POINTER));
